// [shared/hbp_regs.svh]
// register indices, field positions, reset values and counts of the blanking pattern generator
`ifndef HBP_REGS_SVH
`define HBP_REGS_SVH
// ---------------------------------------------------------------
// register indices (byte address = 4 * index)
// ---------------------------------------------------------------
`define HBP_IDX_TOG_FIRST 8'h19
`define HBP_IDX_TOG_LAST  8'h1E
`define HBP_IDX_WIDTH     8'h35
`define HBP_IDX_START_A   8'h36
`define HBP_IDX_START_B   8'h37
`define HBP_IDX_START_C   8'h38
`define HBP_IDX_ODD_SEL   8'h39
`define HBP_IDX_CTRL      8'h3A
`define HBP_IDX_AREA_LEN  8'h3B
`define HBP_IDX_STATUS    8'h3C
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define HBP_WIDTH_LSB     4
`define HBP_WIDTH_MSB     7
`define HBP_RETIME_LSB    20
`define HBP_RETIME_MSB    23
`define HBP_PH1_LSB       0
`define HBP_PH1_MSB       11
`define HBP_PH2_LSB       12
`define HBP_PH2_MSB       23
`define HBP_CTRL_ADV      0
`define HBP_CTRL_THREE    1
`define HBP_SEL_W         3
// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define HBP_POS_MAX       13'h1FFF
`define HBP_LAST_AREA     3'h5
`define HBP_HSIZE_WORD    3'h2
`endif

// [shared/hbp_pkg.sv]
// types shared by the blanking pattern generator modules
package hbp_pkg;
   typedef enum logic [1:0] {HBP_IDLE, HBP_AREA, HBP_DONE} hbp_seq_t;
   typedef logic [25:0] hbp_word_t;
   typedef struct packed {
      hbp_word_t [5:0]   area_word;
      logic [3:0]        width;
      logic [3:0]        retime;
      logic [12:0]       start_a;
      logic [12:0]       start_b;
      logic [12:0]       start_c;
      logic [5:0][2:0]   odd_sel;
      logic              adv_mode;
      logic              three_phase;
      logic [12:0]       area_len;
      logic [31:0]       hrdata;
      logic              wr_pend;
      logic [7:0]        wr_idx;
      hbp_seq_t          st;
      logic [2:0]        area;
      logic [12:0]       pos;
      logic              odd_line;
      logic [3:0]        p1_cnt;
      logic [3:0]        p2_cnt;
      logic              ph1;
      logic              ph2;
      logic              free_clk;
      logic              blank_d;
   } hbp_state_t;
   typedef struct packed {
      logic [4:0] cnt;
      logic       tick;
   } hbp_div_t;
   typedef struct packed {
      logic       blank_d;
      logic [7:0] hclk_out;
   } hbp_rt_t;
endpackage

// [src/hbp_rate_div.sv]
// blanking clock rate divider: one-cycle tick every 2n clocks, every clock when n is 0
`timescale 1ns/1ns
`include "hbp_regs.svh"
module hbp_rate_div import hbp_pkg::*; (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       en,
   input  wire logic [3:0] width,
   output logic            tick
);
   hbp_div_t s;
   hbp_div_t n;
   logic [4:0] term;

   // ---------------------------------------------------------------
   // divider
   // ---------------------------------------------------------------
   always_comb begin
      n = s;
      term = {width, 1'b0} - 5'h01;
      if (!en) begin
         n.cnt = 5'h00;
         n.tick = 1'b0;
      end else if (width == 4'h0) begin
         n.tick = 1'b1;
      end else if (s.cnt >= term) begin
         n.cnt = 5'h00;
         n.tick = 1'b1;
      end else begin
         n.cnt = s.cnt + 5'h01;
         n.tick = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign tick = s.tick;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_div_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
      (tick && en && width != 4'h0 && $stable(width)) |=> !tick)
      else $error("divided blanking tick came on two adjacent cycles");
   a_div_full: assert property (@(posedge hclk) disable iff (!hresetn)
      (en && $past(en) && width == 4'h0 && $past(width) == 4'h0) |-> tick)
      else $error("width zero did not keep the pixel rate");
endmodule

// [src/hbp_retime.sv]
// per-phase fine retime of the blanking mask in three-phase mode only, and output registers for the eight clock outputs
`timescale 1ns/1ns
`include "hbp_regs.svh"
module hbp_retime import hbp_pkg::*; (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       blank,
   input  wire logic       three_phase,
   input  wire logic [3:0] retime,
   input  wire logic       ph1,
   input  wire logic       ph2,
   input  wire logic       free_clk,
   output logic [7:0]      hclk_out
);
   hbp_rt_t s;
   hbp_rt_t n;
   logic [2:0] blank_eff;
   logic [2:0] pat;
   logic [2:0] free;
   logic [7:0] out_nxt;

   function automatic logic [1:0] phase_of(input int i, input logic three);
      phase_of = three ? 2'(i % 3) : 2'(i % 2);
   endfunction

   // ---------------------------------------------------------------
   // phase sources
   // ---------------------------------------------------------------
   assign pat  = {ph1, ph2, ph1};
   assign free = {free_clk, ~free_clk, free_clk};

   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_phase
         // a late internal sample point shifts the mask one clock for this phase only
         assign blank_eff[p] = (three_phase && retime[p]) ? s.blank_d : blank;
      end
   endgenerate

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_out
         assign out_nxt[i] = blank_eff[phase_of(i, three_phase)] ? pat[phase_of(i, three_phase)]
                                                                : free[phase_of(i, three_phase)];
      end
   endgenerate

   always_comb begin
      n = s;
      n.blank_d = blank;
      n.hclk_out = out_nxt;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign hclk_out = s.hclk_out;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_retime_delay: assert property (@(posedge hclk) disable iff (!hresetn)
      (three_phase && retime[0] && blank && !s.blank_d) |=> hclk_out[0] == $past(free[0]))
      else $error("retimed phase one blanked one clock early");
   a_pixel_outside: assert property (@(posedge hclk) disable iff (!hresetn)
      (!blank && !s.blank_d) |=> hclk_out[0] == $past(free_clk))
      else $error("phase one lost the pixel rate outside blanking");
endmodule

// [src/hbp_pattern_gen.sv]
// horizontal blanking pattern generator: AHB-Lite registers, repeat-area sequencer, clock outputs
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ns
`include "hbp_regs.svh"
module hbp_pattern_gen import hbp_pkg::*; (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        line_sync,
   input  wire logic        horizontal_blanking,
   output logic [7:0]       hclk_out,
   output logic             hclock_phase1,
   output logic             hclock_phase2
);
   hbp_state_t s;
   hbp_state_t n;
   logic       tick;
   logic       take;
   logic [2:0] sel_area;
   logic       sel_ok;
   hbp_word_t  cur_word;
   logic       ready_r;
   logic       ready_nxt;

   // ---------------------------------------------------------------
   // decoding helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] reg_index(input logic [31:0] a);
      reg_index = a[9:2];
   endfunction

   function automatic logic is_area(input logic [7:0] idx);
      is_area = (idx >= `HBP_IDX_TOG_FIRST) && (idx <= `HBP_IDX_TOG_LAST);
   endfunction

   function automatic logic [3:0] nib(input logic [11:0] w, input logic [1:0] k);
      nib = w[{k, 2'b00} +: 4];
   endfunction

   function automatic logic [31:0] read_mux(input hbp_state_t r, input logic [7:0] idx);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (is_area(idx)) begin
         d[25:0] = r.area_word[3'(idx - `HBP_IDX_TOG_FIRST)];
      end
      unique case (idx)
         `HBP_IDX_WIDTH: begin
            d[`HBP_WIDTH_MSB:`HBP_WIDTH_LSB]   = r.width;
            d[`HBP_RETIME_MSB:`HBP_RETIME_LSB] = r.retime;
         end
         `HBP_IDX_START_A: d[12:0] = r.start_a;
         `HBP_IDX_START_B: d[12:0] = r.start_b;
         `HBP_IDX_START_C: d[12:0] = r.start_c;
         `HBP_IDX_ODD_SEL: d[17:0] = r.odd_sel;
         `HBP_IDX_CTRL: begin
            d[`HBP_CTRL_ADV]   = r.adv_mode;
            d[`HBP_CTRL_THREE] = r.three_phase;
         end
         `HBP_IDX_AREA_LEN: d[12:0] = r.area_len;
         `HBP_IDX_STATUS: d[5:0] = {r.area, r.st == HBP_AREA, r.st == HBP_DONE, r.odd_line};
         default: d = d;
      endcase
      read_mux = d;
   endfunction

   // ---------------------------------------------------------------
   // repeat-area source selection
   // ---------------------------------------------------------------
   assign take     = hsel && hready && htrans[1];
   assign sel_area = s.odd_line ? s.odd_sel[s.area] : s.area;
   assign sel_ok   = sel_area <= `HBP_LAST_AREA;
   // an out-of-range selector gives an empty slot rather than an undefined pattern
   assign cur_word = sel_ok ? s.area_word[sel_area] : '0;
   assign ready_nxt = 1'b1;

   hbp_rate_div u_div (
      .hclk    (hclk),
      .hresetn (hresetn),
      .en      (s.blank_d && s.adv_mode),
      .width   (s.width),
      .tick    (tick)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      n = s;
      // bus: write data of the previous address phase lands now
      if (s.wr_pend) begin
         if (is_area(s.wr_idx)) begin
            n.area_word[3'(s.wr_idx - `HBP_IDX_TOG_FIRST)] = hwdata[25:0];
         end
         unique case (s.wr_idx)
            `HBP_IDX_WIDTH: begin
               n.width  = hwdata[`HBP_WIDTH_MSB:`HBP_WIDTH_LSB];
               n.retime = hwdata[`HBP_RETIME_MSB:`HBP_RETIME_LSB];
            end
            `HBP_IDX_START_A: n.start_a = hwdata[12:0];
            `HBP_IDX_START_B: n.start_b = hwdata[12:0];
            `HBP_IDX_START_C: n.start_c = hwdata[12:0];
            `HBP_IDX_ODD_SEL: n.odd_sel = hwdata[17:0];
            `HBP_IDX_CTRL: begin
               n.adv_mode    = hwdata[`HBP_CTRL_ADV];
               n.three_phase = hwdata[`HBP_CTRL_THREE];
            end
            `HBP_IDX_AREA_LEN: n.area_len = hwdata[12:0];
            default: n.wr_idx = s.wr_idx;
         endcase
      end
      n.wr_pend = take && hwrite && (hsize == `HBP_HSIZE_WORD);
      n.wr_idx  = take ? reg_index(haddr) : s.wr_idx;
      // read from the next state, so a read right after a write sees the new value
      n.hrdata  = (take && !hwrite) ? read_mux(n, reg_index(haddr)) : 32'h0000_0000;

      // line parity and the free-running pixel-rate clock
      n.blank_d  = horizontal_blanking;
      n.free_clk = ~s.free_clk;
      if (line_sync) begin
         n.odd_line = ~s.odd_line;
      end

      // pulse trains advance on the divided tick only
      if (tick && s.p1_cnt != 4'h0) begin
         n.ph1 = ~s.ph1;
         if (s.ph1) begin
            n.p1_cnt = s.p1_cnt - 4'h1;
         end
      end
      if (tick && s.p2_cnt != 4'h0) begin
         n.ph2 = ~s.ph2;
         if (s.ph2) begin
            n.p2_cnt = s.p2_cnt - 4'h1;
         end
      end

      unique case (s.st)
         HBP_IDLE: begin
            n.p1_cnt = 4'h0;
            n.p2_cnt = 4'h0;
            n.ph1    = 1'b0;
            n.ph2    = 1'b0;
            // with adv_mode clear, blanking holds the outputs at rest for the whole interval
            if (horizontal_blanking && !s.blank_d && s.adv_mode) begin
               n.st   = HBP_AREA;
               n.area = 3'h0;
               n.pos  = 13'h0000;
            end
         end
         HBP_AREA: begin
            n.pos = s.pos + 13'h0001;
            // starts are measured from the current area's own beginning
            if (s.pos == s.start_a) begin
               n.p1_cnt = nib(cur_word[`HBP_PH1_MSB:`HBP_PH1_LSB], 2'h0);
               n.p2_cnt = nib(cur_word[`HBP_PH2_MSB:`HBP_PH2_LSB], 2'h0);
               n.ph1    = 1'b0;
               n.ph2    = 1'b0;
            end
            if (s.pos == s.start_b) begin
               n.p1_cnt = nib(cur_word[`HBP_PH1_MSB:`HBP_PH1_LSB], 2'h1);
               n.p2_cnt = nib(cur_word[`HBP_PH2_MSB:`HBP_PH2_LSB], 2'h1);
               n.ph1    = 1'b0;
               n.ph2    = 1'b0;
            end
            if (s.pos == s.start_c) begin
               n.p1_cnt = nib(cur_word[`HBP_PH1_MSB:`HBP_PH1_LSB], 2'h2);
               n.p2_cnt = nib(cur_word[`HBP_PH2_MSB:`HBP_PH2_LSB], 2'h2);
               n.ph1    = 1'b0;
               n.ph2    = 1'b0;
            end
            if (s.pos == s.area_len) begin
               n.pos = 13'h0000;
               if (s.area == `HBP_LAST_AREA) begin
                  n.st = HBP_DONE;
               end else begin
                  n.area = s.area + 3'h1;
               end
            end
            if (!horizontal_blanking) begin
               n.st = HBP_IDLE;
            end
         end
         HBP_DONE: begin
            if (!horizontal_blanking) begin
               n.st = HBP_IDLE;
            end
         end
         // the fourth code of the state type is unused; recover to idle
         default: n.st = HBP_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s          <= '0;
         s.start_a  <= `HBP_POS_MAX;
         s.start_b  <= `HBP_POS_MAX;
         s.start_c  <= `HBP_POS_MAX;
         s.area_len <= `HBP_POS_MAX;
         s.st       <= HBP_IDLE;
         ready_r    <= 1'b1;
      end else begin
         s       <= n;
         ready_r <= ready_nxt;
      end
   end

   hbp_retime u_retime (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .blank       (s.blank_d),
      .three_phase (s.three_phase),
      .retime      (s.retime),
      .ph1         (s.ph1),
      .ph2         (s.ph2),
      .free_clk    (s.free_clk),
      .hclk_out    (hclk_out)
   );

   assign hrdata        = s.hrdata;
   assign hreadyout     = ready_r;
   assign hresp         = 1'b0;
   assign hclock_phase1 = hclk_out[0];
   assign hclock_phase2 = hclk_out[1];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_write_start_a;
      take && hwrite && hsize == `HBP_HSIZE_WORD && reg_index(haddr) == `HBP_IDX_START_A;
   endsequence

   sequence s_area_end;
      s.st == HBP_AREA && s.pos == s.area_len && horizontal_blanking;
   endsequence

   a_start_write: assert property (@(posedge hclk) disable iff (!hresetn)
      s_write_start_a ##1 1'b1 |=> s.start_a == $past(hwdata[12:0]))
      else $error("start A did not take the written pixel location");
   a_odd_reorder: assert property (@(posedge hclk) disable iff (!hresetn)
      (s.st == HBP_AREA && s.odd_line && s.odd_sel[s.area] <= `HBP_LAST_AREA)
         |-> cur_word == s.area_word[s.odd_sel[s.area]])
      else $error("odd line slot did not reproduce the selected even area");
   a_area_bound: assert property (@(posedge hclk) disable iff (!hresetn)
      s.area <= `HBP_LAST_AREA)
      else $error("repeat area index went past the sixth area");
   a_area_step: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_area_end and (s.area != `HBP_LAST_AREA)) |=> s.pos == 13'h0000 && s.area == $past(s.area) + 3'h1)
      else $error("repeat area did not advance to the next one from position zero");
   a_zero_group: assert property (@(posedge hclk) disable iff (!hresetn)
      (s.st == HBP_AREA && s.pos == s.start_a && s.pos != s.start_b && s.pos != s.start_c
         && nib(cur_word[11:0], 2'h0) == 4'h0 && !s.pos[0]) |=> !s.ph1 [*2])
      else $error("zero count still produced a phase one pulse");
   a_count_load: assert property (@(posedge hclk) disable iff (!hresetn)
      (s.st == HBP_AREA && s.pos == s.start_b && s.pos != s.start_c)
         |=> s.p2_cnt == $past(cur_word[`HBP_PH2_LSB + 7:`HBP_PH2_LSB + 4]))
      else $error("start B group loaded the wrong phase two count");
   a_share_store: assert property (@(posedge hclk) disable iff (!hresetn)
      (s.wr_pend && s.wr_idx == `HBP_IDX_TOG_FIRST) |=> s.area_word[0] == $past(hwdata[25:0]))
      else $error("shared count storage missed its write");
   a_idle_rest: assert property (@(posedge hclk) disable iff (!hresetn)
      (s.st == HBP_IDLE) |=> (!s.ph1 && !s.ph2))
      else $error("blanking pulses appeared outside a repeat area");
endmodule

// [test/hbp_ccd_model.sv]
// far-side sensor model: counts horizontal clock pulses and their period inside blanking
`timescale 1ns/1ns
module hbp_ccd_model (
   input  wire logic  hclk,
   input  wire logic  hresetn,
   input  wire logic  blank,
   input  wire logic  ph1,
   input  wire logic  ph2,
   output logic [7:0] n1,
   output logic [7:0] n2,
   output logic [7:0] per
);
   // ---------------------------------------------------------------
   // pulse counting
   // ---------------------------------------------------------------
   logic [7:0] bcnt;
   logic [7:0] since;
   logic       p1_q;
   logic       p2_q;
   // the first cycles of blanking are skipped: the outputs lag the blanking input
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bcnt <= 8'h00;
         since <= 8'h00;
         p1_q <= 1'b0;
         p2_q <= 1'b0;
         n1 <= 8'h00;
         n2 <= 8'h00;
         per <= 8'h00;
      end else begin
         p1_q <= ph1;
         p2_q <= ph2;
         since <= since + 8'h01;
         if (!blank) begin
            bcnt <= 8'h00;
         end else if (bcnt != 8'hFF) begin
            bcnt <= bcnt + 8'h01;
         end
         if (blank && bcnt == 8'h00) begin
            n1 <= 8'h00;
            n2 <= 8'h00;
            per <= 8'h00;
         end
         if (blank && bcnt >= 8'h05) begin
            if (ph1 && !p1_q) begin
               n1 <= n1 + 8'h01;
               per <= since;
               since <= 8'h01;
            end
            if (ph2 && !p2_q) begin
               n2 <= n2 + 8'h01;
            end
         end
      end
   end
endmodule

// [test/hbp_pattern_gen_tb_top.sv]
// testbench: registers, repeat-area pulse counts, blanking rate divide, odd-line reorder
`timescale 1ns/1ns
`include "hbp_regs.svh"
module hbp_pattern_gen_tb_top;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = `HBP_HSIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        line_sync = 1'b0;
   logic        blank = 1'b0;
   logic [7:0]  hclk_out;
   logic        ph1;
   logic        ph2;
   logic [7:0]  n1;
   logic [7:0]  n2;
   logic [7:0]  per;
   logic [31:0] rd;
   int          n_mismatch = 0;
   int          checked = 0;

   always #5 hclk = ~hclk;

   hbp_pattern_gen DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .line_sync(line_sync), .horizontal_blanking(blank),
      .hclk_out(hclk_out), .hclock_phase1(ph1), .hclock_phase2(ph2));
   hbp_ccd_model sensor (.hclk(hclk), .hresetn(hresetn), .blank(blank), .ph1(ph1), .ph2(ph2),
      .n1(n1), .n2(n2), .per(per));

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic end_sim();
      if (n_mismatch == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_rdy();
      int k;
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && k < 50) begin
         k++;
         @(posedge hclk);
      end
      if (k >= 50) begin
         n_mismatch++;
         end_sim();
      end
   endtask
   // address phase held until hready, then data phase held until hready again
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [2:0] sz);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= sz;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d, `HBP_HSIZE_WORD);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0, `HBP_HSIZE_WORD);
      check(rd, exp);
   endtask
   task automatic set_area(input int k, input logic [11:0] p1, input logic [11:0] p2);
      wr(`HBP_IDX_TOG_FIRST + 8'(k), {8'h00, p2, p1});
   endtask
   task automatic run_blank(input int n);
      @(posedge hclk);
      blank <= 1'b1;
      repeat (n) @(posedge hclk);
      blank <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask
   task automatic lsync();
      @(posedge hclk);
      line_sync <= 1'b1;
      @(posedge hclk);
      line_sync <= 1'b0;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      rdc(`HBP_IDX_START_A, 32'h0000_1FFF);
      rdc(`HBP_IDX_START_B, 32'h0000_1FFF);
      rdc(`HBP_IDX_START_C, 32'h0000_1FFF);
      rdc(`HBP_IDX_WIDTH, 32'h0000_0000);
      rdc(8'h10, 32'h0000_0000);
      wr(`HBP_IDX_START_A, 32'hFFFF_FFFF);
      rdc(`HBP_IDX_START_A, 32'h0000_1FFF);
      // a byte-sized write must leave the register alone
      bus(1'b1, `HBP_IDX_START_B, 32'h0, 3'h0);
      rdc(`HBP_IDX_START_B, 32'h0000_1FFF);
      wr(`HBP_IDX_ODD_SEL, 32'h0002_C688);
      rdc(`HBP_IDX_ODD_SEL, 32'h0002_C688);
      wr(`HBP_IDX_WIDTH, 32'h00F0_00F0);
      rdc(`HBP_IDX_WIDTH, 32'h00F0_00F0);
      for (int k = 0; k < 6; k++) begin
         wr(`HBP_IDX_TOG_FIRST + 8'(k), 32'h00AB_C000 | k);
         rdc(`HBP_IDX_TOG_FIRST + 8'(k), 32'h00AB_C000 | k);
      end
   endtask
   task automatic t_areas();
      wr(`HBP_IDX_CTRL, 32'h1);
      wr(`HBP_IDX_WIDTH, 32'h0);
      wr(`HBP_IDX_START_A, 32'h2);
      wr(`HBP_IDX_START_B, 32'h6);
      wr(`HBP_IDX_START_C, 32'h1FFF);
      wr(`HBP_IDX_AREA_LEN, 32'hF);
      // phase1: one pulse after A and k%4 after B; phase2: one after A only
      for (int k = 0; k < 6; k++) begin
         set_area(k, {4'h0, 4'(k % 4), 4'h1}, 12'h001);
      end
      @(posedge hclk);
      blank <= 1'b1;
      repeat (110) @(posedge hclk);
      bus(1'b0, `HBP_IDX_STATUS, 32'h0, `HBP_HSIZE_WORD);
      check(rd[1:0], 32'h2);
      blank <= 1'b0;
      repeat (4) @(posedge hclk);
      check(n1, 32'd13);
      check(n2, 32'd6);
   endtask
   task automatic t_width();
      wr(`HBP_IDX_START_B, 32'h1FFF);
      wr(`HBP_IDX_AREA_LEN, 32'h1F);
      for (int k = 0; k < 6; k++) begin
         set_area(k, k == 0 ? 12'h002 : 12'h000, k == 0 ? 12'h002 : 12'h000);
      end
      for (int n = 1; n < 3; n++) begin
         wr(`HBP_IDX_WIDTH, n << 4);
         run_blank(200);
         check(n1, 32'd2);
         check(per, 4 * n);
      end
   endtask
   task automatic t_pixel();
      logic p;
      wr(`HBP_IDX_WIDTH, 32'h0);
      repeat (4) @(posedge hclk);
      p = ph1;
      for (int i = 0; i < 6; i++) begin
         @(posedge hclk);
         check(ph1 ^ p, 32'h1);
         check(ph1 ^ ph2, 32'h1);
         check(hclk_out, {4{ph2, ph1}});
         p = ph1;
      end
   endtask
   // three-phase: retime on phase one only shifts its mask, so outputs 0 and 2 differ
   // for exactly one cycle over an odd-length blanking interval
   task automatic t_three();
      int d;
      d = 0;
      wr(`HBP_IDX_CTRL, 32'h3);
      wr(`HBP_IDX_WIDTH, 32'h0010_0000);
      @(posedge hclk);
      check(hclk_out, {ph2, ph1, ph1, ph2, ph1, ph1, ph2, ph1});
      blank <= 1'b1;
      for (int c = 0; c < 121; c++) begin
         @(posedge hclk);
         if (c == 110) begin
            blank <= 1'b0;
         end
         d += int'(hclk_out[0] !== hclk_out[2]);
      end
      check(d, 32'd1);
   endtask
   task automatic t_odd();
      wr(`HBP_IDX_AREA_LEN, 32'hF);
      for (int k = 0; k < 6; k++) begin
         set_area(k, k == 0 ? 12'h001 : k == 1 ? 12'h004 : 12'h000, 12'h000);
      end
      // odd slot 0 repeats area 1, the other slots select nothing
      wr(`HBP_IDX_ODD_SEL, 32'h0003_6DB1);
      lsync();
      bus(1'b0, `HBP_IDX_STATUS, 32'h0, `HBP_HSIZE_WORD);
      check(rd[0], 32'h1);
      run_blank(110);
      check(n1, 32'd4);
      lsync();
      run_blank(110);
      check(n1, 32'd5);
   endtask

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_areas();
      t_width();
      t_pixel();
      t_odd();
      t_three();
      end_sim();
   end
   initial begin
      #200000;
      n_mismatch++;
      end_sim();
   end
endmodule
